//--- shared/capture_defs.svh
// Register map, field positions, reset values and counts of the capture channel
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH

`define CAP_ADDR_W 4
`define CAP_CTRL_ADDR 4'h0
`define CAP_BUF_ADDR 4'h4

`define CAP_CTRL_RESET 16'h0000
`define CAP_CTRL_WMASK 16'h20e7

`define CAP_STOP_IDLE_BIT 13
`define CAP_TSEL_BIT 7
`define CAP_CPI_MSB 6
`define CAP_CPI_LSB 5
`define CAP_OVF_BIT 4
`define CAP_BNE_BIT 3
`define CAP_MODE_MSB 2
`define CAP_MODE_LSB 0

`define CAP_FIFO_DEPTH 4
`define CAP_CNT_W 3
`define CAP_PTR_W 2
`define CAP_DATA_W 16

`define CAP_PRESC_W 4
`define CAP_PRESC4_LAST 4'h3
`define CAP_PRESC16_LAST 4'hf

`endif

//--- shared/capture_pkg.sv
// Types shared by the capture channel and its buffer
package capture_pkg;

   typedef enum logic [2:0] {
      MODE_OFF = 3'h0,
      MODE_EVERY_EDGE = 3'h1,
      MODE_FALL = 3'h2,
      MODE_RISE = 3'h3,
      MODE_RISE4 = 3'h4,
      MODE_RISE16 = 3'h5,
      MODE_UNUSED = 3'h6,
      MODE_WAKE_PIN = 3'h7
   } capture_mode_t;

   typedef logic [15:0] capture_word_t;

endpackage

//--- rtl/capture_fifo.sv
// Four-entry first-in first-out store for captured timer values
`timescale 1ns/10ps
`include "capture_defs.svh"

module capture_fifo
   import capture_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic flush,
   input wire logic push,
   input wire capture_word_t wr_data,
   input wire logic pop,
   output capture_word_t rd_data,
   output logic [`CAP_CNT_W-1:0] count,
   output logic full,
   output logic empty
);

   capture_word_t mem_r [`CAP_FIFO_DEPTH];
   logic [`CAP_PTR_W-1:0] wr_ptr_r;
   logic [`CAP_PTR_W-1:0] rd_ptr_r;
   logic [`CAP_CNT_W-1:0] count_r;
   logic do_push;
   logic do_pop;

   assign full = (count_r == `CAP_CNT_W'(`CAP_FIFO_DEPTH));
   assign empty = (count_r == '0);
   assign count = count_r;
   assign rd_data = mem_r[rd_ptr_r];
   // A push into a full store is dropped; stored entries stay intact
   assign do_push = push & ~full;
   assign do_pop = pop & ~empty;

   always_ff @(posedge sys_clk) begin
      if (do_push) begin
         mem_r[wr_ptr_r] <= wr_data;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else if (flush) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_r <= wr_ptr_r + 2'h1;
         end
         if (do_pop) begin
            rd_ptr_r <= rd_ptr_r + 2'h1;
         end
         count_r <= count_r + `CAP_CNT_W'(do_push) - `CAP_CNT_W'(do_pop);
      end
   end

   fifo_bound_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      count_r <= `CAP_CNT_W'(`CAP_FIFO_DEPTH))
      else $error("capture store holds more than four entries");

   pop_order_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (do_pop && !do_push && !flush) |=>
      (rd_ptr_r == $past(rd_ptr_r) + 2'h1))
      else $error("read did not advance to the next oldest entry");

endmodule

//--- rtl/input_capture_channel.sv
// Input capture channel with four-entry buffer and Avalon-MM registers
//
// Overview of operation
// - Qualifying pin event stores full 16-bit count
// - Buffer holds four captured values
// - Mode 000 switches the channel off
// - Mode 001 captures on both edges
// - Mode 001 interrupts on every capture
// - Mode 010 captures falling edges only
// - Mode 011 captures every rising edge
// - Mode 100 captures every fourth rising edge
// - Mode 101 captures every sixteenth rising edge
// - Mode 110 unused, behaves as disabled
// - Mode 111 is sleep/idle rising-edge interrupt
// - Pin event can wake from sleep, idle
// - Interrupt after one to four captures
// - Timer select picks second or third timer
// - Read-only overflow flag, hardware cleared
// - Read-only flag shows buffer not empty
// - Stop-in-idle bit halts captures in idle; mode 111 still interrupts
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "capture_defs.svh"

module input_capture_channel
   import capture_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [`CAP_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic capture_input_pin,
   input wire capture_word_t second_timer_count,
   input wire capture_word_t third_timer_count,
   input wire logic cpu_idle,
   input wire logic cpu_sleep,
   output logic capture_irq,
   output logic wake_req
);

   // Modes in which timer values are latched
   function automatic logic mode_captures(input logic [2:0] m);
      begin
         mode_captures = (m != MODE_OFF) && (m != MODE_UNUSED) &&
            (m != MODE_WAKE_PIN);
      end
   endfunction

   // Modes in which the store and the status are held cleared
   function automatic logic mode_off(input logic [2:0] m);
      begin
         mode_off = (m == MODE_OFF) || (m == MODE_UNUSED);
      end
   endfunction

   logic [15:0] ctrl_r;
   logic waitrequest_r;
   logic [31:0] readdata_r;
   logic rd_valid_r;
   logic pin_s1_r;
   logic pin_s2_r;
   logic pin_s3_r;
   logic [`CAP_PRESC_W-1:0] presc_r;
   logic [1:0] icnt_r;
   logic ovf_r;
   logic irq_r;
   logic wake_r;

   logic [2:0] mode;
   logic [1:0] cpi;
   logic stop_idle;
   logic tsel;
   logic halted;
   logic active;
   logic rise;
   logic fall;
   logic presc_hit;
   logic qualify;
   logic cap_evt;
   logic push;
   logic pop;
   logic flush;
   logic wr_acc;
   logic rd_acc;
   logic ctrl_wr;
   logic pin_irq;
   logic cap_irq;
   logic [31:0] rd_mux;
   capture_word_t cap_word;
   capture_word_t head;
   logic [`CAP_CNT_W-1:0] count;
   logic full;
   logic empty;

   assign mode = ctrl_r[`CAP_MODE_MSB:`CAP_MODE_LSB];
   assign cpi = ctrl_r[`CAP_CPI_MSB:`CAP_CPI_LSB];
   assign stop_idle = ctrl_r[`CAP_STOP_IDLE_BIT];
   assign tsel = ctrl_r[`CAP_TSEL_BIT];

   // Bus transfer completes at the edge where waitrequest is low
   assign wr_acc = write & ~waitrequest_r;
   assign rd_acc = read & ~waitrequest_r;
   assign ctrl_wr = wr_acc & (address == `CAP_CTRL_ADDR);
   assign pop = rd_acc & (address == `CAP_BUF_ADDR) & rd_valid_r;

   assign waitrequest = waitrequest_r;
   assign readdata = readdata_r;
   assign capture_irq = irq_r;
   assign wake_req = wake_r;

   // Avalon-MM slave handshake: one wait cycle per transfer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         waitrequest_r <= 1'b1;
      end else if (!waitrequest_r) begin
         waitrequest_r <= 1'b1;
      end else if (read || write) begin
         waitrequest_r <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (address)
         `CAP_CTRL_ADDR: begin
            rd_mux[15:0] = ctrl_r & `CAP_CTRL_WMASK;
            rd_mux[`CAP_OVF_BIT] = ovf_r;
            rd_mux[`CAP_BNE_BIT] = ~empty;
         end
         `CAP_BUF_ADDR: begin
            rd_mux[15:0] = empty ? 16'h0000 : head;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // Read data is latched as waitrequest falls and stands at the accept
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         readdata_r <= 32'h0000_0000;
         rd_valid_r <= 1'b0;
      end else if (waitrequest_r && read) begin
         readdata_r <= rd_mux;
         rd_valid_r <= ~empty;
      end
   end

   // Control register; status bits are not writable
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= `CAP_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_r <= writedata[15:0] & `CAP_CTRL_WMASK;
      end
   end

   // Pin synchroniser; the second and third stages feed edge detection
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_s3_r <= 1'b0;
      end else begin
         pin_s1_r <= capture_input_pin;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   assign rise = pin_s2_r & ~pin_s3_r;
   assign fall = ~pin_s2_r & pin_s3_r;

   assign halted = stop_idle & cpu_idle;
   assign active = mode_captures(mode) & ~halted;

   always_comb begin
      presc_hit = 1'b0;
      case (mode)
         MODE_RISE4: presc_hit = (presc_r == `CAP_PRESC4_LAST);
         MODE_RISE16: presc_hit = (presc_r == `CAP_PRESC16_LAST);
         default: presc_hit = 1'b0;
      endcase
   end

   always_comb begin
      qualify = 1'b0;
      case (mode)
         MODE_EVERY_EDGE: qualify = rise | fall;
         MODE_FALL: qualify = fall;
         MODE_RISE: qualify = rise;
         MODE_RISE4: qualify = rise & presc_hit;
         MODE_RISE16: qualify = rise & presc_hit;
         default: qualify = 1'b0;
      endcase
   end

   assign cap_evt = active & qualify;
   assign push = cap_evt & ~full;
   assign flush = mode_off(mode);
   // Time base: set bit takes the second timer, clear the third
   assign cap_word = tsel ? second_timer_count
      : third_timer_count;

   // Prescaler of rising edges, restarted by every control write
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         presc_r <= '0;
      end else if (ctrl_wr || !active) begin
         presc_r <= '0;
      end else if (rise && (mode == MODE_RISE4 || mode == MODE_RISE16)) begin
         presc_r <= presc_hit ? '0 : presc_r + 4'h1;
      end
   end

   // Overflow: set wins over the hardware clear on a read that drains
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ovf_r <= 1'b0;
      end else if (cap_evt && full) begin
         ovf_r <= 1'b1;
      end else if (flush || (pop && count == `CAP_CNT_W'(1))) begin
         ovf_r <= 1'b0;
      end
   end

   // Captures per interrupt; every-edge mode interrupts on each capture
   always_comb begin
      cap_irq = 1'b0;
      if (push) begin
         if (mode == MODE_EVERY_EDGE) begin
            cap_irq = 1'b1;
         end else begin
            cap_irq = (icnt_r == cpi);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         icnt_r <= 2'h0;
      end else if (ctrl_wr || flush) begin
         icnt_r <= 2'h0;
      end else if (push && mode != MODE_EVERY_EDGE) begin
         icnt_r <= cap_irq ? 2'h0 : icnt_r + 2'h1;
      end
   end

   // Wake-pin mode acts only while the processor sleeps or idles
   assign pin_irq = (mode == MODE_WAKE_PIN) & (cpu_sleep | cpu_idle) &
      rise;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_r <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         irq_r <= cap_irq | pin_irq;
         wake_r <= (cpu_sleep | cpu_idle) &
            (pin_irq | cap_irq);
      end
   end

   capture_fifo u_fifo (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .flush(flush),
      .push(push),
      .wr_data(cap_word),
      .pop(pop),
      .rd_data(head),
      .count(count),
      .full(full),
      .empty(empty)
   );

   off_no_capture_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (mode_off(mode) || mode == MODE_WAKE_PIN) |-> !push)
      else $error("capture taken while channel is off");

   unused_mode_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (mode == MODE_UNUSED && rise) |=> (count == '0))
      else $error("unused mode left values in the buffer");

   timer_select_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (push && empty) |=> (head == (($past(tsel)) ?
      $past(second_timer_count) : $past(third_timer_count))))
      else $error("captured word is not the selected timer count");

   fall_only_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (mode == MODE_FALL && push) |-> (pin_s3_r && !pin_s2_r))
      else $error("falling-edge mode captured on another edge");

   every_edge_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (mode == MODE_EVERY_EDGE && !halted && (rise || fall) && !full)
      |=> irq_r)
      else $error("every-edge capture missed or gave no interrupt");

   presc_four_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (mode == MODE_RISE4 && push) |-> (presc_r == 4'h3))
      else $error("divide-by-four capture at wrong edge count");

   presc_sixteen_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (mode == MODE_RISE16 && push) |-> (presc_r == 4'hf))
      else $error("divide-by-sixteen capture at wrong edge count");

   irq_count_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (push && mode != MODE_EVERY_EDGE && icnt_r == cpi) |=> irq_r)
      else $error("interrupt not raised after selected captures");

   overflow_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (cap_evt && full) |=> (ovf_r &&
      count == `CAP_CNT_W'(4) - `CAP_CNT_W'($past(pop))))
      else $error("overflow not flagged or entry lost on full buffer");

   bne_status_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (read && waitrequest_r && address == `CAP_CTRL_ADDR) |=>
      (readdata_r[`CAP_BNE_BIT] == ($past(count) != '0)))
      else $error("buffer-not-empty status disagrees with buffer");

   idle_halt_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (stop_idle && cpu_idle) |-> !cap_evt)
      else $error("capture taken while halted in idle");

   wake_pin_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (mode == MODE_WAKE_PIN && cpu_sleep && rise) |=>
      (wake_r && irq_r))
      else $error("wake pin rising edge gave no wake or interrupt");

   wake_capture_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      (cpu_idle && cap_irq) |=> wake_r)
      else $error("capture interrupt in idle gave no wake request");

   answer_time_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      ((read || write) && waitrequest_r) |=> !waitrequest_r)
      else $error("bus request not answered after one wait cycle");

endmodule

//--- sim/pin_source.sv
// Signal source model that drives the capture input pin
`timescale 1ns/10ps
module pin_source (
   input wire logic sys_clk,
   input wire logic start,
   input wire logic [5:0] pulses,
   input wire logic [3:0] hold,
   output logic pin,
   output logic busy,
   output logic [7:0] edge_cnt
);
   logic [5:0] left_r = 6'h00;
   logic [3:0] hold_r = 4'h0;
   initial begin
      pin = 1'b0;
      busy = 1'b0;
      edge_cnt = 8'h00;
   end
   // Each level stands hold+1 clocks, wide enough for the synchroniser
   always @(posedge sys_clk) begin
      if (start) begin
         left_r <= pulses;
         busy <= (pulses != 6'h00);
         edge_cnt <= 8'h00;
         hold_r <= 4'h0;
      end else if (busy) begin
         if (hold_r != hold) begin
            hold_r <= hold_r + 4'h1;
         end else begin
            hold_r <= 4'h0;
            pin <= !pin;
            edge_cnt <= edge_cnt + 8'h01;
            if (pin) begin
               left_r <= left_r - 6'h01;
               busy <= (left_r != 6'h01);
            end
         end
      end
   end
endmodule

//--- sim/input_capture_channel_tb_top.sv
// Self-checking bench for the input capture channel
`timescale 1ns/10ps
`include "capture_defs.svh"
module input_capture_channel_tb_top
   import capture_pkg::*;
;
   typedef struct {
      logic [2:0] mode;
      logic [1:0] cpi;
      logic tsel;
      int pls, ncap, first, step, nirq;
   } row_t;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [`CAP_ADDR_W-1:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest, capture_input_pin, capture_irq, wake_req;
   logic cpu_idle = 1'b0;
   logic cpu_sleep = 1'b0;
   logic start = 1'b0;
   logic [5:0] pulses = 6'h00;
   logic [3:0] hold = 4'h3;
   logic busy;
   logic [7:0] ecnt;
   capture_word_t second_timer_count, third_timer_count;
   int error_cnt = 0;
   int tests_run = 0;
   int irq_n = 0;
   int wake_n = 0;
   row_t rows [8] = '{
      '{3'h0, 2'h0, 1'b1, 2, 0, 0, 0, 0},
      '{3'h1, 2'h3, 1'b0, 2, 4, 1, 1, 4},
      '{3'h2, 2'h1, 1'b1, 2, 2, 2, 2, 1},
      '{3'h3, 2'h2, 1'b0, 3, 3, 1, 2, 1},
      '{3'h4, 2'h0, 1'b1, 8, 2, 7, 8, 2},
      '{3'h5, 2'h0, 1'b0, 16, 1, 31, 0, 1},
      '{3'h6, 2'h0, 1'b1, 2, 0, 0, 0, 0},
      '{3'h7, 2'h0, 1'b0, 2, 0, 0, 0, 0}
   };
   // Timer values follow the pin edge count so each capture is traceable
   assign second_timer_count = {8'h20, ecnt};
   assign third_timer_count = {8'h30, ecnt};
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (capture_irq === 1'b1) irq_n++;
      if (wake_req === 1'b1) wake_n++;
   end
   input_capture_channel input_capture_channel_inst (
      .sys_clk, .rstn, .address, .read, .write, .writedata, .readdata,
      .waitrequest, .capture_input_pin, .second_timer_count,
      .third_timer_count, .cpu_idle, .cpu_sleep, .capture_irq, .wake_req
   );
   pin_source pin_source_inst (
      .sys_clk, .start, .pulses, .hold, .pin(capture_input_pin), .busy,
      .edge_cnt(ecnt)
   );
   task automatic finish_test;
      $display("Checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
         error_cnt++;
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [15:0] d, output logic [31:0] q);
      int i;
      @(posedge sys_clk);
      address <= a;
      writedata <= {16'h0000, d};
      read <= !wr;
      write <= wr;
      for (i = 0; i < 50; i++) begin
         @(posedge sys_clk);
         if (waitrequest === 1'b0) break;
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (i == 50) begin
         error_cnt++;
         finish_test;
      end
   endtask
   task automatic run(input logic [5:0] n, input logic [3:0] h);
      int i;
      pulses <= n;
      hold <= h;
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      for (i = 0; i < 2000; i++) begin
         @(posedge sys_clk);
         if (busy === 1'b0) break;
      end
      if (i == 2000) begin
         error_cnt++;
         finish_test;
      end
      repeat (8) @(posedge sys_clk);
   endtask
   initial begin
      logic [31:0] q;
      logic [15:0] c;
      row_t r;
      int k;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      check({29'h0, waitrequest, capture_irq, wake_req}, 32'h4);
      check(readdata, 32'h0);
      bus(1'b0, `CAP_CTRL_ADDR, 16'h0000, q);
      check(q, 32'h0);
      bus(1'b1, 4'h8, 16'hffff, q);
      bus(1'b0, 4'h8, 16'h0000, q);
      check(q, 32'h0);
      bus(1'b1, `CAP_CTRL_ADDR, 16'hffff, q);
      bus(1'b0, `CAP_CTRL_ADDR, 16'h0000, q);
      check(q, 32'h20e7);
      bus(1'b1, `CAP_CTRL_ADDR, 16'h0000, q);
      foreach (rows[i]) begin
         r = rows[i];
         c = {8'h00, r.tsel, r.cpi, 2'b00, r.mode};
         bus(1'b1, `CAP_CTRL_ADDR, c, q);
         irq_n = 0;
         run(6'(r.pls), 4'h3);
         bus(1'b0, `CAP_CTRL_ADDR, 16'h0000, q);
         check(q, {16'h0, c | ((r.ncap > 0) ? 16'h0008 : 16'h0)});
         for (k = 0; k < r.ncap; k++) begin
            bus(1'b0, `CAP_BUF_ADDR, 16'h0000, q);
            c = {r.tsel ? 8'h20 : 8'h30, 8'(r.first + k * r.step)};
            check(q, {16'h0, c});
         end
         check(32'(irq_n), 32'(r.nirq));
         bus(1'b1, `CAP_CTRL_ADDR, 16'h0000, q);
      end
      // Five captures into a four-entry buffer with a slow source
      bus(1'b1, `CAP_CTRL_ADDR, 16'h0003, q);
      run(6'd5, 4'h8);
      bus(1'b0, `CAP_CTRL_ADDR, 16'h0000, q);
      check(q, 32'h001b);
      for (k = 0; k < 4; k++) begin
         bus(1'b0, `CAP_BUF_ADDR, 16'h0000, q);
         check(q, {16'h0, 8'h30, 8'(2 * k + 1)});
      end
      bus(1'b0, `CAP_BUF_ADDR, 16'h0000, q);
      check(q, 32'h0);
      bus(1'b0, `CAP_CTRL_ADDR, 16'h0000, q);
      check(q, 32'h0003);
      // Idle with and without the stop-in-idle bit
      cpu_idle <= 1'b1;
      bus(1'b1, `CAP_CTRL_ADDR, 16'h2003, q);
      run(6'd1, 4'h3);
      bus(1'b0, `CAP_CTRL_ADDR, 16'h0000, q);
      check(q, 32'h2003);
      bus(1'b1, `CAP_CTRL_ADDR, 16'h0003, q);
      wake_n = 0;
      run(6'd1, 4'h3);
      bus(1'b0, `CAP_CTRL_ADDR, 16'h0000, q);
      check(q, 32'h000b);
      check(32'(wake_n), 32'h1);
      cpu_idle <= 1'b0;
      // Wake pin mode while asleep
      cpu_sleep <= 1'b1;
      bus(1'b1, `CAP_CTRL_ADDR, 16'h0007, q);
      irq_n = 0;
      wake_n = 0;
      run(6'd1, 4'h3);
      check(32'(irq_n), 32'h1);
      check(32'(wake_n), 32'h1);
      cpu_sleep <= 1'b0;
      // Reset after a completed run returns control and buffer to zero
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      check({29'h0, waitrequest, capture_irq, wake_req}, 32'h4);
      check(readdata, 32'h0);
      bus(1'b0, `CAP_CTRL_ADDR, 16'h0000, q);
      check(q, 32'h0);
      bus(1'b0, `CAP_BUF_ADDR, 16'h0000, q);
      check(q, 32'h0);
      finish_test;
   end
endmodule
